//--- rtl/spi_diag_pkg.sv
// package: constants shared by the serial diagnosis slave port and its master end
// assumes: both ends run on one system clock of 250 MHz
package spi_diag_pkg;
    localparam int unsigned FRAME_BITS = 8;
    localparam int unsigned CNT_W = 3;
    // control bits in the top of each command byte
    localparam logic [1:0] CMD_WRITE_CTRL = 2'b11;
    localparam logic [1:0] CMD_READ_CTRL = 2'b10;
    localparam int unsigned CMD_HI = 7;
    localparam int unsigned CMD_LO = 6;
    // diagnosis control field layout
    localparam int unsigned SEL_HI = 2;
    localparam int unsigned SEL_LO = 0;
    localparam int unsigned BYPASS_BIT = 3;
    localparam logic [2:0] SEL_RESET = 3'h7;
    localparam logic [2:0] SEL_LAST_CH = 3'h4;
    localparam logic [2:0] SEL_STANDBY = 3'h7;
    // standard diagnosis layout
    localparam int unsigned UNDEF_BIT = 6;
    localparam int unsigned CHANNELS = 5;
    // link timing, serial clock half period and lead/lag/gap times
    localparam int unsigned SYS_CLK_MHZ = 250;
    localparam int unsigned SCLK_HALF_NS = 250;
    localparam int unsigned CS_GUARD_NS = 1000;
    localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int unsigned CS_GUARD_CYC = (CS_GUARD_NS * SYS_CLK_MHZ + 999) / 1000;
endpackage : spi_diag_pkg

//--- rtl/spi_diag_if.sv
// interface: the four serial wires between master and slave
// assumes: the master reads the serial output directly; only the checker looks at its enable
`timescale 1ns/1ps
interface spi_diag_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    modport slave (input cs_n, input sclk, input mosi, output miso, output miso_oe);
    modport master (input miso, input miso_oe, output cs_n, output sclk, output mosi);
endinterface : spi_diag_if

//--- rtl/spi_byte_buffer.sv
// two-entry valid/ready buffer for received bytes
// assumes: one clock, both sides synchronous to it
`timescale 1ns/1ps
module spi_byte_buffer #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    // the pointer and count logic below serves exactly two entries
    if (DEPTH != 2) begin : g_depth_check
        $error("buffer depth must be 2");
    end
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] head_ff;
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    logic [1:0] count_ff;
    logic valid_ff;
    wire push = i_valid && o_ready;
    wire pop = valid_ff && i_ready;
    wire nxt_rd_ptr = rd_ptr_ff ^ pop;
    wire [1:0] nxt_count = count_ff + {1'b0, push} - {1'b0, pop};
    // a byte pushed into the slot that becomes the head bypasses the array
    wire head_from_input = push && (wr_ptr_ff == nxt_rd_ptr);
    assign o_ready = (count_ff != 2'h2);
    assign o_valid = valid_ff;
    assign o_data = head_ff;
    always_ff @(posedge i_sys_clk) begin
        if (push) mem_ff[wr_ptr_ff] <= i_data;
        head_ff <= head_from_input ? i_data : mem_ff[nxt_rd_ptr];
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff <= 2'h0;
            valid_ff <= 1'b0;
        end else begin
            if (push) wr_ptr_ff <= ~wr_ptr_ff;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
            valid_ff <= (nxt_count != 2'h0);
        end
    end
endmodule : spi_byte_buffer

//--- rtl/spi_diag_slave_port.sv
// slave end: serial diagnosis port with control and diagnosis registers
// assumes: link pins come from another domain; analog status arrives as levels
`timescale 1ns/1ps
module spi_diag_slave_port (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // serial link
    spi_diag_if.slave link,
    // analog status levels
    input wire logic [spi_diag_pkg::CHANNELS-1:0] i_channel_output_state,
    input wire logic [spi_diag_pkg::CHANNELS-1:0] i_channel_error_flag,
    input wire logic i_bypass_above,
    input wire logic i_undefined_status_flag,
    // sense output control
    output logic [2:0] o_sense_select,
    output logic o_sense_output_en,
    output logic o_standby,
    output logic o_transmission_error_flag,
    // received byte stream
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    input wire logic i_rx_ready
);
    // the frame decode below is written for one byte counted in three bits
    if (spi_diag_pkg::CNT_W != 3 || spi_diag_pkg::FRAME_BITS != 8) begin : g_frame_check
        $error("frame must be eight bits with a three-bit count");
    end
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] cs_sync_ff;
    logic [2:0] sclk_sync_ff;
    logic [2:0] mosi_sync_ff;
    // reset levels match the pins' idle levels, so no false edge follows reset
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_sync_ff <= 3'h7;
            sclk_sync_ff <= 3'h0;
            mosi_sync_ff <= 3'h0;
        end else begin
            cs_sync_ff <= {cs_sync_ff[1:0], link.cs_n};
            sclk_sync_ff <= {sclk_sync_ff[1:0], link.sclk};
            mosi_sync_ff <= {mosi_sync_ff[1:0], link.mosi};
        end
    end
    // a change counts once stages two and three agree
    logic cs_n_ff;
    logic sclk_ff;
    logic mosi_ff;
    wire cs_n_now = (cs_sync_ff[1] == cs_sync_ff[2]) ? cs_sync_ff[2] : cs_n_ff;
    wire sclk_now = (sclk_sync_ff[1] == sclk_sync_ff[2]) ? sclk_sync_ff[2] : sclk_ff;
    wire mosi_now = (mosi_sync_ff[1] == mosi_sync_ff[2]) ? mosi_sync_ff[2] : mosi_ff;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_n_ff <= 1'b1;
            sclk_ff <= 1'b0;
            mosi_ff <= 1'b0;
        end else begin
            cs_n_ff <= cs_n_now;
            sclk_ff <= sclk_now;
            mosi_ff <= mosi_now;
        end
    end
    wire cs_fall = cs_n_ff && !cs_n_now;
    wire cs_rise = !cs_n_ff && cs_n_now;
    wire active = !cs_n_ff && !cs_n_now;
    wire sclk_fall = active && sclk_ff && !sclk_now;
    wire sclk_rise = active && !sclk_ff && sclk_now;
    // ****************************************
    // shift engine and registers
    // ****************************************
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic [spi_diag_pkg::CNT_W-1:0] bit_cnt_ff;
    logic any_bits_ff;
    logic out_bit_ff;
    logic out_en_ff;
    logic ter_ff;
    logic [2:0] sel_ff;
    logic read_ctrl_ff;
    logic buf_ready;
    wire [7:0] ctrl_word = {4'h0, (sel_ff == spi_diag_pkg::SEL_STANDBY) ? 1'b0 : i_bypass_above, sel_ff};
    wire [7:0] diag_word = {1'b0, i_undefined_status_flag, 1'b0, i_channel_error_flag};
    wire [7:0] load_word = read_ctrl_ff ? ctrl_word : diag_word;
    // a frame with no clock at all fails the count check like any short one
    wire frame_ok = any_bits_ff && (bit_cnt_ff == '0);
    wire [1:0] cmd = shift_ff[spi_diag_pkg::CMD_HI:spi_diag_pkg::CMD_LO];
    // a write with bit 3 set is refused whole, so a garbled byte never half-applies
    wire do_write = cs_rise && frame_ok && cmd == spi_diag_pkg::CMD_WRITE_CTRL && !shift_ff[spi_diag_pkg::BYPASS_BIT];
    wire do_read = cs_rise && frame_ok && cmd == spi_diag_pkg::CMD_READ_CTRL;
    wire byte_done = sclk_fall && (bit_cnt_ff == 3'h7);
    // sample and shift happen in the same register, msb first
    always_comb begin
        nxt_shift = shift_ff;
        if (cs_fall) nxt_shift = load_word;
        else if (sclk_fall) nxt_shift = {shift_ff[6:0], mosi_ff};
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) shift_ff <= 8'h00;
        else shift_ff <= nxt_shift;
    end
    // the count restarts on every select fall, so a cut frame never leaks into the next
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            bit_cnt_ff <= '0;
            any_bits_ff <= 1'b0;
        end else if (cs_fall) begin
            bit_cnt_ff <= '0;
            any_bits_ff <= 1'b0;
        end else if (sclk_fall) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            any_bits_ff <= 1'b1;
        end
    end
    // in a chain the first bit carries any upstream error onward
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            out_bit_ff <= 1'b0;
            out_en_ff <= 1'b0;
        end else if (cs_fall) begin
            out_bit_ff <= ter_ff | mosi_now;
            out_en_ff <= 1'b1;
        end else if (cs_rise) begin
            out_en_ff <= 1'b0;
        end else if (sclk_rise) begin
            out_bit_ff <= shift_ff[7];
        end
    end
    // an error flag set by a bad frame wins over the clear of a good frame
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ter_ff <= 1'b0;
            sel_ff <= spi_diag_pkg::SEL_RESET;
            read_ctrl_ff <= 1'b0;
        end else begin
            if (cs_rise && !frame_ok) ter_ff <= 1'b1;
            else if (cs_rise) ter_ff <= 1'b0;
            if (do_write) sel_ff <= shift_ff[2:0];
            // the response chosen here is what the next select fall loads
            if (cs_rise && frame_ok) read_ctrl_ff <= do_read || do_write;
        end
    end
    // ****************************************
    // sense output and outputs
    // ****************************************
    // one compare per channel keeps the select from indexing past the last channel
    logic [spi_diag_pkg::CHANNELS-1:0] route_hit;
    for (genvar ch = 0; ch < spi_diag_pkg::CHANNELS; ch++) begin : g_route
        assign route_hit[ch] = (sel_ff == 3'(ch)) && i_channel_output_state[ch];
    end
    // codes past the last channel, standby included, never route
    wire sel_on = (sel_ff <= spi_diag_pkg::SEL_LAST_CH) && (|route_hit);
    logic sense_en_ff;
    logic standby_ff;
    // registered so the sense pin does not glitch while the select settles
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sense_en_ff <= 1'b0;
            standby_ff <= 1'b1;
        end else begin
            sense_en_ff <= sel_on;
            standby_ff <= (sel_ff == spi_diag_pkg::SEL_STANDBY);
        end
    end
    assign link.miso = out_bit_ff;
    assign link.miso_oe = out_en_ff;
    assign o_sense_select = sel_ff;
    assign o_sense_output_en = sense_en_ff;
    assign o_standby = standby_ff;
    assign o_transmission_error_flag = ter_ff;
    // ****************************************
    // received byte stream
    // ****************************************
    // the link cannot be stalled: a byte that meets a full buffer is dropped
    spi_byte_buffer #(.WIDTH(8), .DEPTH(2)) u_rx_buf (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_valid(byte_done),
        .i_data(nxt_shift),
        .o_ready(buf_ready),
        .o_valid(o_rx_valid),
        .o_data(o_rx_data),
        .i_ready(i_rx_ready)
    );
endmodule : spi_diag_slave_port

//--- rtl/spi_diag_master.sv
// master end: sends one byte per request, returns the byte shifted back
// assumes: slave samples pins; divider makes the serial clock from system clock
`timescale 1ns/1ps
module spi_diag_master (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // serial link
    spi_diag_if.master link,
    // request
    input wire logic i_req_valid,
    input wire logic [7:0] i_req_data,
    output logic o_req_ready,
    // answer
    output logic o_rsp_valid,
    output logic [7:0] o_rsp_data,
    output logic o_rsp_flag
);
    typedef enum {ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_LAG, ST_GAP} mst_state_t;
    mst_state_t state_ff;
    logic [15:0] tmr_ff;
    logic [2:0] bit_ff;
    logic [7:0] tx_ff;
    logic [7:0] rx_ff;
    logic cs_n_ff;
    logic sclk_ff;
    logic mosi_ff;
    logic flag_ff;
    logic rsp_valid_ff;
    logic [2:0] miso_sync_ff;
    wire tick = (tmr_ff == 16'h0000);
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) miso_sync_ff <= 3'h0;
        else miso_sync_ff <= {miso_sync_ff[1:0], link.miso};
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
            tmr_ff <= 16'h0000;
            bit_ff <= 3'h0;
            tx_ff <= 8'h00;
            rx_ff <= 8'h00;
            cs_n_ff <= 1'b1;
            sclk_ff <= 1'b0;
            mosi_ff <= 1'b0;
            flag_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= 1'b0;
            if (!tick) tmr_ff <= tmr_ff - 16'h0001;
            case (state_ff)
                ST_IDLE: if (i_req_valid) begin
                    tx_ff <= {i_req_data[6:0], 1'b0};
                    mosi_ff <= i_req_data[7];
                    cs_n_ff <= 1'b0;
                    tmr_ff <= 16'(spi_diag_pkg::CS_GUARD_CYC);
                    bit_ff <= 3'h0;
                    state_ff <= ST_LEAD;
                end
                ST_LEAD: if (tick) begin
                    flag_ff <= miso_sync_ff[2];
                    sclk_ff <= 1'b1;
                    tmr_ff <= 16'(spi_diag_pkg::SCLK_HALF_CYC);
                    state_ff <= ST_HIGH;
                end
                ST_HIGH: if (tick) begin
                    sclk_ff <= 1'b0;
                    rx_ff <= {rx_ff[6:0], miso_sync_ff[2]};
                    tmr_ff <= 16'(spi_diag_pkg::SCLK_HALF_CYC);
                    state_ff <= (bit_ff == 3'h7) ? ST_LAG : ST_LOW;
                end
                ST_LOW: if (tick) begin
                    mosi_ff <= tx_ff[7];
                    tx_ff <= {tx_ff[6:0], 1'b0};
                    bit_ff <= bit_ff + 3'h1;
                    sclk_ff <= 1'b1;
                    tmr_ff <= 16'(spi_diag_pkg::SCLK_HALF_CYC);
                    state_ff <= ST_HIGH;
                end
                ST_LAG: if (tick) begin
                    cs_n_ff <= 1'b1;
                    rsp_valid_ff <= 1'b1;
                    tmr_ff <= 16'(spi_diag_pkg::CS_GUARD_CYC);
                    state_ff <= ST_GAP;
                end
                ST_GAP: if (tick) state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
    assign o_req_ready = (state_ff == ST_IDLE);
    assign link.cs_n = cs_n_ff;
    assign link.sclk = sclk_ff;
    assign link.mosi = mosi_ff;
    assign o_rsp_valid = rsp_valid_ff;
    assign o_rsp_data = rx_ff;
    assign o_rsp_flag = flag_ff;
endmodule : spi_diag_master

//--- sim/spi_diag_props.sv
// checker: timing relations on the serial wires between master and slave
// assumes: instantiated beside the interface, one system clock domain
`timescale 1ns/1ps
module spi_diag_props (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // link wires
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    // ****************
    // wire checks
    // ****************
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // counts serial clock rises inside one frame
    logic [3:0] rise_cnt_ff;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            rise_cnt_ff <= 4'h0;
        else if (cs_n)
            rise_cnt_ff <= 4'h0;
        else if ($rose(sclk))
            rise_cnt_ff <= rise_cnt_ff + 4'h1;
    end
    idle_float_a: assert property (cs_n [*6] |-> !miso_oe)
        else $error("serial output driven while deselected");
    drive_start_a: assert property ($fell(cs_n) ##1 (!cs_n) [*7] |-> miso_oe)
        else $error("serial output not driven after select");
    first_bit_a: assert property ($fell(cs_n) ##1 (!cs_n && !sclk && mosi) [*7] |-> miso)
        else $error("first output bit ignores input level");
    cs_clk_low_a: assert property ($changed(cs_n) |-> !sclk)
        else $error("select moved with clock high");
    clk_idle_a: assert property (cs_n [*2] |-> !sclk)
        else $error("serial clock runs outside a frame");
    miso_quiet_a: assert property ((!cs_n && !sclk) [*8] |-> $stable(miso))
        else $error("serial output moved while clock low");
    bit_count_a: assert property ($rose(cs_n) |-> rise_cnt_ff == 4'h8)
        else $error("frame closed without eight clocks");
    out_release_a: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
        else $error("serial output not released");
endmodule : spi_diag_props

//--- sim/tb_spi_diag_slave_port.sv
// testbench: master and slave on one link, a second slave bit-banged by hand
// assumes: package, interface and design modules compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_spi_diag_slave_port;
    // hand-made link clock: 128 ns, sixteen 4 ns cycles in each half period
    localparam int SCLK_HALF = 16;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic req_valid = 1'b0;
    logic [7:0] req_data = 8'h00;
    logic [4:0] chan_on = 5'h15;
    logic [4:0] chan_err = 5'h16;
    logic bypass = 1'b1;
    logic rx_ready = 1'b0;
    logic req_ready, rsp_valid, rsp_flag, sense_en, standby, transmission_error_flag, rx_valid, ter2, f;
    logic [7:0] rsp_data, rx_data, r;
    logic [2:0] sel, sel2;
    int n_errors = 0;
    int num_checks = 0;
    spi_diag_if lk ();
    spi_diag_if lk2 ();
    spi_diag_master i_spi_diag_master (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(lk.master),
        .i_req_valid(req_valid), .i_req_data(req_data), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid),
        .o_rsp_data(rsp_data), .o_rsp_flag(rsp_flag));
    spi_diag_slave_port i_spi_diag_slave_port (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(lk.slave),
        .i_channel_output_state(chan_on), .i_channel_error_flag(chan_err), .i_bypass_above(bypass),
        .i_undefined_status_flag(1'b1), .o_sense_select(sel), .o_sense_output_en(sense_en), .o_standby(standby),
        .o_transmission_error_flag(transmission_error_flag), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready));
    spi_diag_slave_port i_spi_diag_slave_port_2 (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(lk2.slave),
        .i_channel_output_state(chan_on), .i_channel_error_flag(chan_err), .i_bypass_above(bypass),
        .i_undefined_status_flag(1'b1), .o_sense_select(sel2), .o_sense_output_en(), .o_standby(),
        .o_transmission_error_flag(ter2), .o_rx_valid(), .o_rx_data(), .i_rx_ready(1'b1));
    spi_diag_props i_spi_diag_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .cs_n(lk.cs_n), .sclk(lk.sclk),
        .mosi(lk.mosi), .miso(lk.miso), .miso_oe(lk.miso_oe));
    always #2 i_sys_clk = ~i_sys_clk;
    // ****************
    // access tasks
    // ****************
    task automatic xchk(input logic [7:0] d, input logic [7:0] exp);
        bit took = 1'b0;
        bit done = 1'b0;
        req_valid <= 1'b1;
        req_data <= d;
        // the master stays busy through the gap after a frame, about 250 cycles
        for (int k = 0; k < 400 && !took; k++) begin
            @(posedge i_sys_clk);
            took = (req_ready === 1'b1);
        end
        req_valid <= 1'b0;
        for (int k = 0; k < 4000 && !done; k++) begin
            @(posedge i_sys_clk);
            done = (rsp_valid === 1'b1);
        end
        // a handshake that never came counts as a mismatch
        if (!took || !done) n_errors++;
        r = rsp_data;
        f = rsp_flag;
        // the slave acts a few cycles after the master, through its synchronisers
        repeat (8) @(posedge i_sys_clk);
        `CHK(r, exp)
        `CHK(f, d[7])
    endtask : xchk
    // frame of n clocks on the second link, byte repeated every eight bits
    task automatic bb(input int n, input logic [7:0] d, input logic exp_f);
        lk2.cs_n <= 1'b0;
        lk2.mosi <= d[7];
        repeat (spi_diag_pkg::CS_GUARD_CYC) @(posedge i_sys_clk);
        `CHK(lk2.miso, exp_f)
        for (int i = 0; i < n; i++) begin
            repeat (SCLK_HALF) @(posedge i_sys_clk);
            lk2.sclk <= 1'b1;
            // data moves on the rise, so it stands a half period before the sampling fall
            lk2.mosi <= d[7 - i % 8];
            repeat (SCLK_HALF) @(posedge i_sys_clk);
            lk2.sclk <= 1'b0;
        end
        repeat (spi_diag_pkg::CS_GUARD_CYC) @(posedge i_sys_clk);
        lk2.cs_n <= 1'b1;
        lk2.mosi <= ~d[0];
        repeat (spi_diag_pkg::CS_GUARD_CYC) @(posedge i_sys_clk);
    endtask : bb
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // ****************
    // tests
    // ****************
    initial begin
        repeat (80000) @(posedge i_sys_clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        lk2.cs_n = 1'b1;
        lk2.sclk = 1'b0;
        lk2.mosi = 1'b0;
        repeat (16) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        xchk(8'h80, 8'h56);
        xchk(8'h00, 8'h07);
        `CHK(standby, 1'b1)
        xchk(8'h00, 8'h56);
        // two bytes held while the receiver stalls, the third is lost
        `CHK(rx_valid, 1'b1)
        `CHK(rx_data, 8'h80)
        rx_ready <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        `CHK(rx_data, 8'h00)
        @(posedge i_sys_clk);
        `CHK(rx_valid, 1'b0)
        $display("test reset_and_buffer done");
        for (int s = 0; s < 7; s++) begin
            bypass <= s[0];
            @(posedge i_sys_clk);
            xchk(8'hC0 | 8'(s), (s == 0) ? 8'h56 : {4'h0, s[0], 3'(s - 1)});
            `CHK(sel, 3'(s))
            `CHK(standby, 1'b0)
            `CHK(sense_en, (s < 5) && chan_on[s])
            xchk(8'h80, {4'h0, s[0], 3'(s)});
        end
        xchk(8'h00, 8'h06);
        xchk(8'hCB, 8'h56);
        `CHK(sel, 3'h6)
        `CHK(transmission_error_flag, 1'b0)
        xchk(8'hC7, 8'h56);
        `CHK(standby, 1'b1)
        `CHK(sense_en, 1'b0)
        $display("test select_sweep done");
        bb(5, 8'hC3, 1'b1);
        `CHK(ter2, 1'b1)
        `CHK(sel2, 3'h7)
        bb(8, 8'h00, 1'b1);
        `CHK(ter2, 1'b0)
        bb(8, 8'hC2, 1'b1);
        `CHK(sel2, 3'h2)
        bb(16, 8'hC5, 1'b1);
        `CHK(sel2, 3'h5)
        bb(8, 8'h42, 1'b0);
        bb(0, 8'h00, 1'b0);
        `CHK(ter2, 1'b1)
        $display("test framing done");
        wrap_up();
    end
endmodule : tb_spi_diag_slave_port
